// ---- ddpsc_host_model.sv ----
// behavioural serial host that frames commands toward the pot block
`timescale 1ns/1ps
module ddpsc_host_model (
   input wire logic i_clk_sys, // bench clock the host steps on
   input wire logic i_so, // serial data from the block
   output logic o_sck, // serial clock, still between frames
   output logic o_si, // serial data
   output logic o_cs_n, // chip select, active low
   output logic o_hold_n // pause, active low
);
   // idle levels: deselected, clock low, pause unused
   initial begin
      o_sck = 1'b0;
      o_si = 1'b0;
      o_cs_n = 1'b1;
      o_hold_n = 1'b1;
   end
   // half of the 80 ns serial period
   task automatic half();
      repeat (4) @(negedge i_clk_sys);
   endtask
   // one byte msb first; returned bit taken late in the high phase
   task automatic xbyte(input logic [7:0] tx, input bit pause, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         o_si = tx[i];
         half();
         // pause mid low phase so the block has already seen the clock fall
         if (pause && i == 3) begin
            o_hold_n = 1'b0;
            repeat (20) @(negedge i_clk_sys);
            o_hold_n = 1'b1;
            half();
         end
         o_sck = 1'b1;
         half();
         rx[i] = i_so;
         o_sck = 1'b0;
      end
   endtask
   // id, instruction and data or read byte inside one select
   task automatic frame(input logic [7:0] id, ins, dat, input bit pause, output logic [7:0] rd);
      logic [7:0] junk;
      o_cs_n = 1'b0;
      half();
      xbyte(id, 1'b0, junk);
      xbyte(ins, 1'b0, junk);
      xbyte(dat, pause, rd);
      half();
      o_cs_n = 1'b1;
      o_si = ~o_si; // released line shows no stale bit
      repeat (8) @(negedge i_clk_sys);
   endtask
endmodule

// ---- ddpsc_pkg.sv ----
// shared constants, types and command codes of the dual pot serial control block
package ddpsc_pkg;
   // ====================================================================
   // array geometry
   localparam int POT_CNT = 2;
   localparam int TAP_BITS = 8;
   localparam int ELEM_CNT = 255;
   localparam int TAP_CNT = ELEM_CNT + 1;
   localparam int SAVED_CNT = 4;
   localparam logic [7:0] SAVED_RST = 8'h80;
   localparam logic [1:0] DEFAULT_SAVED_IDX = 2'h0;
   // ====================================================================
   // identification byte layout: type nibble, zero pair, strap pair
   localparam logic [3:0] DEV_TYPE_ID = 4'h6; // arbitrary value
   localparam int ID_TYPE_MSB = 7;
   localparam int ID_TYPE_LSB = 4;
   localparam int ID_ZERO_MSB = 3;
   localparam int ID_ZERO_LSB = 2;
   localparam int ID_ADDR_HI = 1;
   localparam int ID_ADDR_LO = 0;
   // ====================================================================
   // instruction byte layout: opcode nibble, pot bit, saved index
   localparam int INS_OP_MSB = 7;
   localparam int INS_OP_LSB = 4;
   localparam int INS_POT_BIT = 2;
   localparam int INS_REG_MSB = 1;
   localparam int INS_REG_LSB = 0;
   localparam logic [3:0] OP_RD_WIPER = 4'h9;
   localparam logic [3:0] OP_WR_WIPER = 4'hA;
   localparam logic [3:0] OP_RD_SAVED = 4'hB;
   localparam logic [3:0] OP_WR_SAVED = 4'hC;
   localparam logic [3:0] OP_XFR_TO_WIPER = 4'hD;
   localparam logic [3:0] OP_XFR_TO_SAVED = 4'hE;
   localparam logic [2:0] LAST_BIT = 3'h7;
   // ====================================================================
   // pin group sampled from outside the clock domain
   typedef struct packed {
      logic sck;
      logic si;
      logic cs_n;
      logic hold_n;
      logic wp_n;
      logic strap_hi;
      logic strap_lo;
   } ddpsc_pins_t;
   localparam ddpsc_pins_t PINS_RST = 7'h1C;
   // ====================================================================
   // serial sequence states
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_ID = 6'h02,
      ST_INSTR = 6'h04,
      ST_DATA_IN = 6'h08,
      ST_DATA_OUT = 6'h10,
      ST_IGNORE = 6'h20
   } ddpsc_state_t;
endpackage

// ---- ddpsc_tap_dec.sv ----
// registered one-hot decoder from wiper position to tap switch enables
`timescale 1ns/1ps
module ddpsc_tap_dec #(
   parameter int W = 8
) (
   input wire logic i_clk_sys, // system clock
   input wire logic i_nrst, // async reset, active low
   input wire logic [W-1:0] i_pos, // wiper position
   output logic [(1<<W)-1:0] o_tap // one-hot switch enables
);
   logic [(1<<W)-1:0] next_tap;

   // exactly one enable per position
   always_comb begin
      next_tap = '0;
      next_tap[i_pos] = 1'b1;
   end

   // register the enables; reset selects tap zero
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         o_tap <= {{((1<<W)-1){1'b0}}, 1'b1};
      end else begin
         o_tap <= next_tap;
      end
   end
endmodule

// ---- ddpsc_top.sv ----
// serial control of two digital pots: wiper and saved-setting registers
`timescale 1ns/1ps
module ddpsc_top
   import ddpsc_pkg::*;
#(
   parameter int NPOT = ddpsc_pkg::POT_CNT,
   parameter int NSAVED = ddpsc_pkg::SAVED_CNT,
   parameter logic [3:0] TYPE_ID = ddpsc_pkg::DEV_TYPE_ID // arbitrary value
) (
   input wire logic i_clk_sys, // system clock
   input wire logic i_nrst, // async reset, active low
   input wire logic i_sck, // serial clock pin
   input wire logic i_si, // serial data in pin
   input wire logic i_cs_n, // chip select, active low
   input wire logic i_hold_n, // pause input, active low
   input wire logic i_wp_n, // write protect, active low
   input wire logic i_slave_addr_strap_lo, // address strap bit 0
   input wire logic i_slave_addr_strap_hi, // address strap bit 1
   output logic o_so, // serial data out
   output logic o_so_oe, // serial out drive enable
   output logic [ddpsc_pkg::TAP_CNT-1:0] o_tap_sel0, // pot 0 switch enables
   output logic [ddpsc_pkg::TAP_CNT-1:0] o_tap_sel1, // pot 1 switch enables
   output logic [7:0] o_wiper0, // pot 0 wiper position
   output logic [7:0] o_wiper1 // pot 1 wiper position
);
   import ddpsc_pkg::*;

   // ====================================================================
   // pin synchronisers
   ddpsc_pins_t pins_raw;
   ddpsc_pins_t meta;
   ddpsc_pins_t pins;
   logic sck_prev;

   assign pins_raw = '{sck: i_sck, si: i_si, cs_n: i_cs_n, hold_n: i_hold_n,
                       wp_n: i_wp_n, strap_hi: i_slave_addr_strap_hi,
                       strap_lo: i_slave_addr_strap_lo};

   // two flops per pin, then one more on the clock for edge finding
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         meta <= PINS_RST;
         pins <= PINS_RST;
         sck_prev <= 1'b0;
      end else begin
         meta <= pins_raw;
         pins <= meta;
         sck_prev <= pins.sck;
      end
   end

   // ====================================================================
   // control and storage state
   ddpsc_state_t state, next_state;
   logic [2:0] cnt, next_cnt;
   logic [7:0] sh, next_sh;
   logic [7:0] out_sh, next_out_sh;
   logic [3:0] op, next_op;
   logic pot, next_pot;
   logic [1:0] ridx, next_ridx;
   logic so, next_so;
   logic so_oe, next_so_oe;
   logic cs_prev, next_cs_prev;
   logic armed, next_armed;
   logic recalled, next_recalled;
   logic [7:0] wiper_position_reg [NPOT];
   logic [7:0] next_wiper [NPOT];
   logic [7:0] saved [NPOT][NSAVED];
   logic [7:0] next_saved [NPOT][NSAVED];
   logic sck_rise, sck_fall, sel, run;
   logic [7:0] byte_in;

   // read one saved setting
   function automatic logic [7:0] saved_rd(input logic p, input logic [1:0] r,
                                           input logic [7:0] s [NPOT][NSAVED]);
      saved_rd = s[p][r];
   endfunction

   // opcode expects a data byte from the host
   function automatic logic is_write(input logic [3:0] o);
      is_write = (o == OP_WR_WIPER) || (o == OP_WR_SAVED);
   endfunction

   assign sck_rise = pins.sck && !sck_prev;
   assign sck_fall = !pins.sck && sck_prev;
   assign sel = armed && !pins.cs_n;
   assign run = sel && pins.hold_n;
   assign byte_in = {sh[6:0], pins.si};

   // serial sequencer, register writes, transfers and recall
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_sh = sh;
      next_out_sh = out_sh;
      next_op = op;
      next_pot = pot;
      next_ridx = ridx;
      next_so = so;
      next_wiper = wiper_position_reg;
      next_saved = saved;
      next_cs_prev = pins.cs_n;
      next_armed = armed;
      next_recalled = 1'b1;
      // default saved setting loads each wiper once after power-up
      if (!recalled) begin
         for (int p = 0; p < NPOT; p++) begin
            next_wiper[p] = saved[p][DEFAULT_SAVED_IDX];
         end
      end
      // a fall of chip select arms the port and starts a new sequence
      if (cs_prev && !pins.cs_n) begin
         next_armed = 1'b1;
         next_state = ST_ID;
         next_cnt = 3'h0;
      end else if (pins.cs_n) begin
         next_state = ST_IDLE;
         next_cnt = 3'h0;
      end else if (run && sck_rise && state != ST_DATA_OUT) begin
         next_sh = byte_in;
         next_cnt = cnt + 3'h1;
         if (cnt == LAST_BIT) begin
            case (state)
               ST_ID: begin
                  if (byte_in[ID_TYPE_MSB:ID_TYPE_LSB] == TYPE_ID &&
                      byte_in[ID_ZERO_MSB:ID_ZERO_LSB] == 2'h0 &&
                      byte_in[ID_ADDR_HI] == pins.strap_hi &&
                      byte_in[ID_ADDR_LO] == pins.strap_lo) begin
                     next_state = ST_INSTR;
                  end else begin
                     next_state = ST_IGNORE;
                  end
               end
               ST_INSTR: begin
                  next_op = byte_in[INS_OP_MSB:INS_OP_LSB];
                  next_pot = byte_in[INS_POT_BIT];
                  next_ridx = byte_in[INS_REG_MSB:INS_REG_LSB];
                  next_state = ST_IGNORE;
                  case (byte_in[INS_OP_MSB:INS_OP_LSB])
                     OP_RD_WIPER: begin
                        next_out_sh = wiper_position_reg[byte_in[INS_POT_BIT]];
                        next_state = ST_DATA_OUT;
                     end
                     OP_RD_SAVED: begin
                        next_out_sh = saved_rd(byte_in[INS_POT_BIT],
                                               byte_in[INS_REG_MSB:INS_REG_LSB],
                                               saved);
                        next_state = ST_DATA_OUT;
                     end
                     OP_XFR_TO_WIPER: begin
                        next_wiper[byte_in[INS_POT_BIT]] =
                           saved_rd(byte_in[INS_POT_BIT],
                                    byte_in[INS_REG_MSB:INS_REG_LSB], saved);
                     end
                     OP_XFR_TO_SAVED: begin
                        if (pins.wp_n) begin
                           next_saved[byte_in[INS_POT_BIT]]
                              [byte_in[INS_REG_MSB:INS_REG_LSB]] =
                              wiper_position_reg[byte_in[INS_POT_BIT]];
                        end
                     end
                     default: begin
                        if (is_write(byte_in[INS_OP_MSB:INS_OP_LSB])) begin
                           next_state = ST_DATA_IN;
                        end
                     end
                  endcase
               end
               ST_DATA_IN: begin
                  next_state = ST_IGNORE;
                  if (op == OP_WR_WIPER) begin
                     next_wiper[pot] = byte_in;
                  end else if (pins.wp_n) begin
                     next_saved[pot][ridx] = byte_in;
                  end
               end
               default: begin
                  next_state = state;
               end
            endcase
         end
      end else if (run && sck_fall && state == ST_DATA_OUT) begin
         next_so = out_sh[7];
         next_out_sh = {out_sh[6:0], 1'b0};
      end
      // output floats when deselected or paused
      next_so_oe = (next_state == ST_DATA_OUT) && run;
   end

   // register the control and storage state
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         state <= ST_IDLE;
         cnt <= 3'h0;
         sh <= 8'h00;
         out_sh <= 8'h00;
         op <= 4'h0;
         pot <= 1'b0;
         ridx <= 2'h0;
         so <= 1'b0;
         so_oe <= 1'b0;
         cs_prev <= 1'b0;
         armed <= 1'b0;
         recalled <= 1'b0;
         for (int p = 0; p < NPOT; p++) begin
            wiper_position_reg[p] <= 8'h00;
            for (int r = 0; r < NSAVED; r++) begin
               saved[p][r] <= SAVED_RST;
            end
         end
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         sh <= next_sh;
         out_sh <= next_out_sh;
         op <= next_op;
         pot <= next_pot;
         ridx <= next_ridx;
         so <= next_so;
         so_oe <= next_so_oe;
         cs_prev <= next_cs_prev;
         armed <= next_armed;
         recalled <= next_recalled;
         wiper_position_reg <= next_wiper;
         saved <= next_saved;
      end
   end

   // ====================================================================
   // outputs and tap decoders (256 taps over 255 elements per string)
   assign o_so = so;
   assign o_so_oe = so_oe;
   assign o_wiper0 = wiper_position_reg[0];
   assign o_wiper1 = wiper_position_reg[1];

   ddpsc_tap_dec #(.W(TAP_BITS)) u_dec0 (
      .i_clk_sys(i_clk_sys),
      .i_nrst(i_nrst),
      .i_pos(wiper_position_reg[0]),
      .o_tap(o_tap_sel0)
   );

   ddpsc_tap_dec #(.W(TAP_BITS)) u_dec1 (
      .i_clk_sys(i_clk_sys),
      .i_nrst(i_nrst),
      .i_pos(wiper_position_reg[1]),
      .o_tap(o_tap_sel1)
   );
endmodule

// ---- ddpsc_top_asserts.sv ----
// concurrent checks on the pins of the dual pot serial control block
`timescale 1ns/1ps
module ddpsc_top_asserts
   import ddpsc_pkg::*;
(
   input wire logic i_clk_sys, // system clock
   input wire logic i_nrst, // async reset, active low
   input wire logic i_sck, // serial clock pin
   input wire logic i_si, // serial data in
   input wire logic i_cs_n, // chip select
   input wire logic i_hold_n, // pause
   input wire logic i_wp_n, // write protect
   input wire logic i_slave_addr_strap_lo, // strap bit 0
   input wire logic i_slave_addr_strap_hi, // strap bit 1
   input wire logic o_so, // serial out
   input wire logic o_so_oe, // serial out enable
   input wire logic [ddpsc_pkg::TAP_CNT-1:0] o_tap_sel0, // pot 0 taps
   input wire logic [ddpsc_pkg::TAP_CNT-1:0] o_tap_sel1, // pot 1 taps
   input wire logic [7:0] o_wiper0, // pot 0 wiper
   input wire logic [7:0] o_wiper1 // pot 1 wiper
);
   // ==================================================================
   // single domain, so clock and reset are given once
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_nrst);
   tap_follow0_a: assert property (o_tap_sel0 == (TAP_CNT'(1) << $past(o_wiper0)))
      else $error("pot 0 tap does not follow wiper");
   tap_follow1_a: assert property (o_tap_sel1 == (TAP_CNT'(1) << $past(o_wiper1)))
      else $error("pot 1 tap does not follow wiper");
   tap_onehot_a: assert property ($onehot(o_tap_sel0) && $onehot(o_tap_sel1))
      else $error("tap enables not one-hot");
   oe_deselect_a: assert property (i_cs_n [*6] |-> !o_so_oe)
      else $error("serial out driven while deselected");
   oe_pause_a: assert property (!i_hold_n [*6] |-> !o_so_oe)
      else $error("serial out driven while paused");
   oe_select_a: assert property ($rose(o_so_oe) |-> !i_cs_n && i_hold_n)
      else $error("serial out enabled without selection");
   so_steady_a: assert property (!i_cs_n && $rose(i_sck) |-> ##1 $stable(o_so) [*3])
      else $error("serial out moved after clock rise");
   wiper_idle_a: assert property (i_cs_n [*8] |-> $stable(o_wiper0) && $stable(o_wiper1))
      else $error("wiper moved while deselected");
   wiper_pause_a: assert property (!i_hold_n [*8] |-> $stable({o_wiper0, o_wiper1}))
      else $error("wiper moved while paused");
endmodule

// ---- tb.sv ----
// self-checking bench for the dual pot serial control block
`timescale 1ns/1ps
module tb;
   import ddpsc_pkg::*;
   logic clk, nrst, sck, si, cs_n, hold_n, wp_n, st_lo, st_hi, so, so_oe;
   logic [TAP_CNT-1:0] tap0, tap1;
   logic [7:0] wip0, wip1, rd;
   logic [7:0] exp_w [2];
   logic [7:0] exp_s [2][4];
   logic [3:0] ops [6] = '{OP_RD_WIPER, OP_WR_WIPER, OP_RD_SAVED, OP_WR_SAVED,
      OP_XFR_TO_WIPER, OP_XFR_TO_SAVED};
   int num_errors = 0;
   int samples_checked = 0;
   int seed = 32'h498f69ed;
   ddpsc_top DUT (.i_clk_sys(clk), .i_nrst(nrst), .i_sck(sck), .i_si(si), .i_cs_n(cs_n),
      .i_hold_n(hold_n), .i_wp_n(wp_n), .i_slave_addr_strap_lo(st_lo),
      .i_slave_addr_strap_hi(st_hi), .o_so(so), .o_so_oe(so_oe), .o_tap_sel0(tap0),
      .o_tap_sel1(tap1), .o_wiper0(wip0), .o_wiper1(wip1));
   ddpsc_host_model u_host (.i_clk_sys(clk), .i_so(so_line), .o_sck(sck), .o_si(si),
      .o_cs_n(cs_n), .o_hold_n(hold_n));
   // serial out line as the host sees it: a released line shows the inverse
   logic so_line;
   assign so_line = so_oe ? so : ~so;
   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   function automatic logic [7:0] id_of(input logic [1:0] a);
      return {DEV_TYPE_ID, 2'h0, a};
   endfunction
   function automatic logic [7:0] ins_of(input logic [3:0] op, input logic p, input logic [1:0] i);
      return {op, 1'b0, p, i};
   endfunction
   task automatic chk(input logic [TAP_CNT-1:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t: got %0h want %0h", $time, got, exp);
      end
   endtask
   // wipers and their decoded tap enables
   task automatic check_pots();
      chk(TAP_CNT'(wip0), TAP_CNT'(exp_w[0]));
      chk(TAP_CNT'(wip1), TAP_CNT'(exp_w[1]));
      chk(tap0, TAP_CNT'(1) << exp_w[0]);
      chk(tap1, TAP_CNT'(1) << exp_w[1]);
   endtask
   // one command frame with the expected effect tracked alongside
   task automatic cmd(input logic [3:0] op, input logic p, input logic [1:0] i,
      input logic [7:0] d, input bit pause);
      u_host.frame(id_of({st_hi, st_lo}), ins_of(op, p, i), d, pause, rd);
      chk(TAP_CNT'(so_oe), '0);
      case (op)
         OP_WR_WIPER: exp_w[p] = d;
         OP_WR_SAVED: if (wp_n) exp_s[p][i] = d;
         OP_XFR_TO_WIPER: exp_w[p] = exp_s[p][i];
         OP_XFR_TO_SAVED: if (wp_n) exp_s[p][i] = exp_w[p];
         OP_RD_WIPER: chk(TAP_CNT'(rd), TAP_CNT'(exp_w[p]));
         default: chk(TAP_CNT'(rd), TAP_CNT'(exp_s[p][i]));
      endcase
      check_pots();
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // hang guard
   initial begin
      repeat (100000) @(posedge clk);
      num_errors++;
      print_verdict();
   end
   // main sequence
   initial begin
      nrst = 1'b0;
      wp_n = 1'b1;
      {st_hi, st_lo} = 2'($random(seed));
      foreach (exp_s[p, i]) exp_s[p][i] = SAVED_RST;
      exp_w = '{SAVED_RST, SAVED_RST};
      repeat (10) @(negedge clk);
      nrst = 1'b1;
      repeat (8) @(negedge clk);
      check_pots();
      $display("test reset_recall done");
      for (int k = 0; k < 18; k++) begin
         wp_n = ($random(seed) % 4) != 0;
         cmd(ops[k % 6], 1'($random(seed)), 2'($random(seed)), 8'($random(seed)), 1'b0);
      end
      $display("test random_ops done");
      cmd(OP_WR_WIPER, 1'b1, 2'h0, ~exp_s[1][3], 1'b0);
      wp_n = 1'b0;
      cmd(OP_WR_SAVED, 1'b0, 2'h1, ~exp_s[0][1], 1'b0);
      cmd(OP_XFR_TO_SAVED, 1'b1, 2'h3, 8'h00, 1'b0);
      cmd(OP_RD_SAVED, 1'b0, 2'h1, 8'h00, 1'b0);
      cmd(OP_RD_SAVED, 1'b1, 2'h3, 8'h00, 1'b0);
      wp_n = 1'b1;
      $display("test write_protect done");
      for (int j = 0; j < 2; j++) begin
         rd = j ? id_of({st_hi, st_lo}) ^ 8'h80 : id_of(~{st_hi, st_lo});
         u_host.frame(rd, ins_of(OP_WR_WIPER, 1'b1, 2'h0), ~exp_w[1], 1'b0, rd);
         check_pots();
      end
      $display("test bad_address done");
      cmd(OP_WR_WIPER, 1'b0, 2'h0, 8'($random(seed)), 1'b1);
      cmd(OP_RD_WIPER, 1'b0, 2'h0, 8'hFF, 1'b1);
      $display("test pause done");
      print_verdict();
   end
endmodule
bind ddpsc_top ddpsc_top_asserts u_chk (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
   .i_sck(i_sck), .i_si(i_si), .i_cs_n(i_cs_n), .i_hold_n(i_hold_n), .i_wp_n(i_wp_n),
   .i_slave_addr_strap_lo(i_slave_addr_strap_lo), .i_slave_addr_strap_hi(i_slave_addr_strap_hi),
   .o_so(o_so), .o_so_oe(o_so_oe), .o_tap_sel0(o_tap_sel0), .o_tap_sel1(o_tap_sel1),
   .o_wiper0(o_wiper0), .o_wiper1(o_wiper1));
